// ==== two_wire_slave_pkg.sv ====
package two_wire_slave_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int TIMEOUT_MS    = 28;
   localparam int TIMEOUT_CYC   = (TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
   localparam int FILTER_CYC    = 2;
   localparam int FIFO_DEPTH    = 4;

   // ==========================================================
   // Framing constants
   localparam logic [4:0] ADDR_BASE     = 5'h12;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] BYTE_IDLE     = 8'hFF;
   localparam logic [7:0] BYTE_ZERO     = 8'h00;

   // Address-select pin connection codes
   localparam logic [1:0] SEL_GND = 2'h0;
   localparam logic [1:0] SEL_VDD = 2'h1;
   localparam logic [1:0] SEL_SDA = 2'h2;
   localparam logic [1:0] SEL_SCL = 2'h3;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_PTR,
      ST_WDATA,
      ST_ACK,
      ST_TX,
      ST_MACK,
      ST_IGNORE
   } bus_state_t;

   typedef struct packed {
      logic [7:0]  ptr;
      logic [15:0] data;
      logic        lowValid;
   } wr_entry_t;

endpackage

// ==== line_filter.sv ====
module line_filter
   import two_wire_slave_pkg::*;
#(
   parameter int   STAGES      = FILTER_CYC,
   parameter logic RESET_LEVEL = 1'b1
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic pinIn,
   output logic      level
);
   localparam int CW = $clog2(STAGES + 1);

   logic          s1_r;
   logic          s2_r;
   logic          level_r;
   logic          level_nxt;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;

   // ==========================================================
   // Glitch filter: a new level must persist before it is taken
   always_comb begin
      level_nxt = level_r;
      cnt_nxt   = '0;
      if (s2_r != level_r) begin
         if (cnt_r == CW'(STAGES - 1)) begin
            level_nxt = s2_r;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_r    <= RESET_LEVEL;
         s2_r    <= RESET_LEVEL;
         level_r <= RESET_LEVEL;
         cnt_r   <= '0;
      end else begin
         s1_r    <= pinIn;
         s2_r    <= s1_r;
         level_r <= level_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   assign level = level_r;

   a_filter_hold: assert property (@(posedge clk) disable iff (!arst_n)
      (s2_r != level_r) && (cnt_r != CW'(STAGES - 1)) |=> $stable(level_r))
      else $error("filtered level moved before the input settled");

   a_filter_take: assert property (@(posedge clk) disable iff (!arst_n)
      (s2_r != level_r) && (cnt_r == CW'(STAGES - 1)) |=> level_r == $past(s2_r))
      else $error("filtered level missed a settled input");

endmodule

// ==== cdc_fifo.sv ====
module cdc_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 4
) (
   input  wire logic             wrClk,
   input  wire logic             rdClk,
   input  wire logic             arst_n,
   input  wire logic             wrValid,
   output logic                  wrReady,
   input  wire logic [WIDTH-1:0] wrData,
   output logic                  rdValid,
   input  wire logic             rdReady,
   output logic [WIDTH-1:0]      rdData
);
   // DEPTH must be a power of two, at least 4
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wBin_r;
   logic [AW:0]      wBin_nxt;
   logic [AW:0]      wGray_r;
   logic [AW:0]      rBin_r;
   logic [AW:0]      rBin_nxt;
   logic [AW:0]      rGray_r;
   logic [AW:0]      rgS1_r;
   logic [AW:0]      rgS2_r;
   logic [AW:0]      wgS1_r;
   logic [AW:0]      wgS2_r;

   function automatic logic [AW:0] toGray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   // ==========================================================
   // Full and empty from gray pointers crossed by two flops each
   assign wrReady = (wGray_r != {~rgS2_r[AW:AW-1], rgS2_r[AW-2:0]});
   assign rdValid = (rGray_r != wgS2_r);
   assign rdData  = mem[rBin_r[AW-1:0]];

   always_comb begin
      wBin_nxt = wBin_r;
      rBin_nxt = rBin_r;
      if (wrValid && wrReady) begin
         wBin_nxt = wBin_r + 1'b1;
      end
      if (rdValid && rdReady) begin
         rBin_nxt = rBin_r + 1'b1;
      end
   end

   always_ff @(posedge wrClk) begin
      if (wrValid && wrReady) begin
         mem[wBin_r[AW-1:0]] <= wrData;
      end
   end

   always_ff @(posedge wrClk or negedge arst_n) begin
      if (!arst_n) begin
         wBin_r  <= '0;
         wGray_r <= '0;
         rgS1_r  <= '0;
         rgS2_r  <= '0;
      end else begin
         wBin_r  <= wBin_nxt;
         wGray_r <= toGray(wBin_nxt);
         rgS1_r  <= rGray_r;
         rgS2_r  <= rgS1_r;
      end
   end

   always_ff @(posedge rdClk or negedge arst_n) begin
      if (!arst_n) begin
         rBin_r  <= '0;
         rGray_r <= '0;
         wgS1_r  <= '0;
         wgS2_r  <= '0;
      end else begin
         rBin_r  <= rBin_nxt;
         rGray_r <= toGray(rBin_nxt);
         wgS1_r  <= wGray_r;
         wgS2_r  <= wgS1_r;
      end
   end

endmodule

// ==== two_wire_slave.sv ====
// Summary of operation
// - With both lines high the bus is idle and the slave never pulls the data line low.
// - Data falling while the clock is high is a start and opens a new address phase.
// - Data rising while the clock is high is a stop and returns the slave to idle.
// - Any number of data bytes is accepted between start and stop while the write FIFO has room; a byte arriving when it is full is not acknowledged.
// - A write ended after one data byte updates only the high byte of the addressed register.
// - The addressed receiver holds the data line low through the whole acknowledge clock pulse.
// - A not-acknowledge from a reading master makes the slave release the data line and stop sending.
// - The two low address bits come from the single address-select pin connection.
// - The pin is judged during each address phase as ground, supply, data or clock, giving 0x48 to 0x4B.
// - The first byte after a write address is stored as the register pointer.
// - Sixteen-bit values travel high byte first, then low byte, in both directions.
// - Either line low for 28 ms inside a transfer resets the interface and releases the bus.
module two_wire_slave
   import two_wire_slave_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter int FILTER_LEN     = FILTER_CYC,
   parameter int FIFO_WORDS     = FIFO_DEPTH
) (
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic        sensorClk,
   input  wire logic        sclIn,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaOe,
   input  wire logic        addressSelectPin,
   output logic             wrValid,
   input  wire logic        wrReady,
   output wr_entry_t        wrEntry,
   output logic [7:0]       rdPtr,
   input  wire logic [15:0] rdData
);
   localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

   // ==========================================================
   // Filtered bus lines
   logic sclF;
   logic sdaF;
   logic selF;
   logic sclPrev_r;
   logic sdaPrev_r;

   line_filter #(.STAGES(FILTER_LEN), .RESET_LEVEL(1'b1)) u_sclFilt (
      .clk    (ref_clk),
      .arst_n (arst_n),
      .pinIn  (sclIn),
      .level  (sclF)
   );
   line_filter #(.STAGES(FILTER_LEN), .RESET_LEVEL(1'b1)) u_sdaFilt (
      .clk    (ref_clk),
      .arst_n (arst_n),
      .pinIn  (sdaIn),
      .level  (sdaF)
   );
   // Same filter depth as the bus lines, so a pin tied to a line tracks it exactly
   line_filter #(.STAGES(FILTER_LEN), .RESET_LEVEL(1'b1)) u_selFilt (
      .clk    (ref_clk),
      .arst_n (arst_n),
      .pinIn  (addressSelectPin),
      .level  (selF)
   );

   logic sclRise;
   logic sclFall;
   logic startDet;
   logic stopDet;

   assign sclRise  = sclF & ~sclPrev_r;
   assign sclFall  = ~sclF & sclPrev_r;
   assign startDet = sclF & sclPrev_r & sdaPrev_r & ~sdaF;
   assign stopDet  = sclF & sclPrev_r & ~sdaPrev_r & sdaF;

   // ==========================================================
   // Engine state
   bus_state_t    state_r,    stateNxt;
   bus_state_t    retState_r, retStateNxt;
   logic [3:0]    bitCnt_r,   bitCntNxt;
   logic [7:0]    shift_r,    shiftNxt;
   logic [7:0]    ptr_r,      ptrNxt;
   logic [7:0]    msb_r,      msbNxt;
   logic          msbHeld_r,  msbHeldNxt;
   logic [7:0]    txSh_r,     txShNxt;
   logic          lowNext_r,  lowNextNxt;
   logic          nack_r,     nackNxt;
   logic          sdaOe_r,    sdaOeNxt;
   logic [TW-1:0] tmo_r,      tmoNxt;
   logic          pushValid_r, pushValidNxt;
   wr_entry_t     pushEntry_r, pushEntryNxt;
   logic          rdReqTgl_r, rdReqTglNxt;
   logic          selLo_r,    selLoNxt;
   logic          selHi_r,    selHiNxt;
   logic          selSda_r,   selSdaNxt;
   logic          fifoWrReady;
   logic          ackS1_r;
   logic          ackS2_r;
   logic          ackTgl_r;
   logic [15:0]   rdWord_r;
   logic          wordOk;
   logic [7:0]    txByte;
   logic [6:0]    ownAddr;
   logic          timeout;

   // A pin that matches none of the first three is taken as tied to the clock line
   function automatic logic [1:0] pinCode(input logic lo, input logic hi, input logic eqSda);
      if (lo) begin
         return SEL_GND;
      end else if (hi) begin
         return SEL_VDD;
      end else if (eqSda) begin
         return SEL_SDA;
      end
      return SEL_SCL;
   endfunction

   assign ownAddr = {ADDR_BASE, pinCode(selLo_r, selHi_r, selSda_r)};
   assign timeout = (state_r != ST_IDLE) && (tmo_r == TW'(TIMEOUT_CYCLES - 1));
   // A word still in flight is never sampled; the master then reads all ones
   assign wordOk  = (ackS2_r == rdReqTgl_r);
   assign txByte  = !wordOk ? BYTE_IDLE : (lowNext_r ? rdWord_r[7:0] : rdWord_r[15:8]);

   always_comb begin
      stateNxt     = state_r;
      retStateNxt  = retState_r;
      bitCntNxt    = bitCnt_r;
      shiftNxt     = shift_r;
      ptrNxt       = ptr_r;
      msbNxt       = msb_r;
      msbHeldNxt   = msbHeld_r;
      txShNxt      = txSh_r;
      lowNextNxt   = lowNext_r;
      nackNxt      = nack_r;
      sdaOeNxt     = sdaOe_r;
      tmoNxt       = tmo_r;
      pushValidNxt = 1'b0;
      pushEntryNxt = pushEntry_r;
      rdReqTglNxt  = rdReqTgl_r;
      selLoNxt     = selLo_r;
      selHiNxt     = selHi_r;
      selSdaNxt    = selSda_r;
      if (startDet || stopDet) begin
         if (msbHeld_r) begin
            pushValidNxt = 1'b1;
            pushEntryNxt = '{ptr: ptr_r, data: {msb_r, BYTE_ZERO}, lowValid: 1'b0};
         end
         msbHeldNxt = 1'b0;
         sdaOeNxt   = 1'b0;
         bitCntNxt  = '0;
         tmoNxt     = '0;
         selLoNxt   = 1'b1;
         selHiNxt   = 1'b1;
         selSdaNxt  = 1'b1;
         stateNxt   = startDet ? ST_ADDR : ST_IDLE;
      end else if (timeout) begin
         stateNxt   = ST_IDLE;
         sdaOeNxt   = 1'b0;
         msbHeldNxt = 1'b0;
         tmoNxt     = '0;
      end else begin
         // Any line movement counts as activity; only a stuck-low line times out
         if (state_r != ST_IDLE) begin
            if ((sclF != sclPrev_r) || (sdaF != sdaPrev_r) || (sclF && sdaF)) begin
               tmoNxt = '0;
            end else begin
               tmoNxt = tmo_r + 1'b1;
            end
         end
         if (state_r == ST_ADDR) begin
            selLoNxt  = selLo_r & ~selF;
            selHiNxt  = selHi_r & selF;
            selSdaNxt = selSda_r & (selF == sdaF);
         end
         case (state_r)
            ST_ADDR, ST_PTR, ST_WDATA: begin
               if (sclRise && (bitCnt_r < BITS_PER_BYTE)) begin
                  shiftNxt  = {shift_r[6:0], sdaF};
                  bitCntNxt = bitCnt_r + 1'b1;
               end else if (sclFall && (bitCnt_r == BITS_PER_BYTE)) begin
                  bitCntNxt = '0;
                  stateNxt  = ST_ACK;
                  sdaOeNxt  = 1'b1;
                  if (state_r == ST_ADDR) begin
                     if (shift_r[7:1] != ownAddr) begin
                        stateNxt = ST_IGNORE;
                        sdaOeNxt = 1'b0;
                     end else if (shift_r[0]) begin
                        retStateNxt = ST_TX;
                        lowNextNxt  = 1'b0;
                        rdReqTglNxt = ~rdReqTgl_r;
                     end else begin
                        retStateNxt = ST_PTR;
                     end
                  end else if (state_r == ST_PTR) begin
                     ptrNxt      = shift_r;
                     retStateNxt = ST_WDATA;
                  end else if (!fifoWrReady) begin
                     // Back-pressure: refuse the byte rather than lose it
                     stateNxt = ST_IGNORE;
                     sdaOeNxt = 1'b0;
                  end else if (!msbHeld_r) begin
                     msbNxt      = shift_r;
                     msbHeldNxt  = 1'b1;
                     retStateNxt = ST_WDATA;
                  end else begin
                     pushValidNxt = 1'b1;
                     pushEntryNxt = '{ptr: ptr_r, data: {msb_r, shift_r}, lowValid: 1'b1};
                     msbHeldNxt   = 1'b0;
                     retStateNxt  = ST_WDATA;
                  end
               end
            end
            ST_ACK: begin
               if (sclFall) begin
                  sdaOeNxt = 1'b0;
                  stateNxt = retState_r;
                  if (retState_r == ST_TX) begin
                     txShNxt    = {txByte[6:0], 1'b0};
                     sdaOeNxt   = ~txByte[7];
                     bitCntNxt  = 4'h1;
                     lowNextNxt = ~lowNext_r;
                  end
               end
            end
            ST_TX: begin
               if (sclFall) begin
                  if (bitCnt_r == BITS_PER_BYTE) begin
                     sdaOeNxt = 1'b0;
                     stateNxt = ST_MACK;
                  end else begin
                     sdaOeNxt  = ~txSh_r[7];
                     txShNxt   = {txSh_r[6:0], 1'b0};
                     bitCntNxt = bitCnt_r + 1'b1;
                  end
               end
            end
            ST_MACK: begin
               if (sclRise) begin
                  nackNxt = sdaF;
               end else if (sclFall) begin
                  if (nack_r) begin
                     stateNxt = ST_IGNORE;
                  end else begin
                     txShNxt    = {txByte[6:0], 1'b0};
                     sdaOeNxt   = ~txByte[7];
                     bitCntNxt  = 4'h1;
                     lowNextNxt = ~lowNext_r;
                     stateNxt   = ST_TX;
                  end
               end
            end
            default: begin
               sdaOeNxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sclPrev_r   <= 1'b1;
         sdaPrev_r   <= 1'b1;
         state_r     <= ST_IDLE;
         retState_r  <= ST_IDLE;
         bitCnt_r    <= '0;
         shift_r     <= '0;
         ptr_r       <= '0;
         msb_r       <= '0;
         msbHeld_r   <= 1'b0;
         txSh_r      <= '0;
         lowNext_r   <= 1'b0;
         nack_r      <= 1'b0;
         sdaOe_r     <= 1'b0;
         tmo_r       <= '0;
         pushValid_r <= 1'b0;
         pushEntry_r <= '0;
         rdReqTgl_r  <= 1'b0;
         selLo_r     <= 1'b1;
         selHi_r     <= 1'b1;
         selSda_r    <= 1'b1;
         ackS1_r     <= 1'b0;
         ackS2_r     <= 1'b0;
      end else begin
         sclPrev_r   <= sclF;
         sdaPrev_r   <= sdaF;
         state_r     <= stateNxt;
         retState_r  <= retStateNxt;
         bitCnt_r    <= bitCntNxt;
         shift_r     <= shiftNxt;
         ptr_r       <= ptrNxt;
         msb_r       <= msbNxt;
         msbHeld_r   <= msbHeldNxt;
         txSh_r      <= txShNxt;
         lowNext_r   <= lowNextNxt;
         nack_r      <= nackNxt;
         sdaOe_r     <= sdaOeNxt;
         tmo_r       <= tmoNxt;
         pushValid_r <= pushValidNxt;
         pushEntry_r <= pushEntryNxt;
         rdReqTgl_r  <= rdReqTglNxt;
         selLo_r     <= selLoNxt;
         selHi_r     <= selHiNxt;
         selSda_r    <= selSdaNxt;
         ackS1_r     <= ackTgl_r;
         ackS2_r     <= ackS1_r;
      end
   end

   // Open drain: the pin only ever pulls low
   assign sdaOut = 1'b0;
   assign sdaOe  = sdaOe_r;

   // ==========================================================
   // Register side, on sensorClk: pointer fetch handshake
   logic        reqS1_r;
   logic        reqS2_r;
   logic        reqS3_r;
   logic        capPend_r, capPendNxt;
   logic        ackTglNxt;
   logic [7:0]  rdPtr_r,   rdPtrNxt;
   logic [15:0] rdWordNxt;

   // ptr_r is stable for the whole handshake, so it is taken as a word
   always_comb begin
      capPendNxt = 1'b0;
      ackTglNxt  = ackTgl_r;
      rdPtrNxt   = rdPtr_r;
      rdWordNxt  = rdWord_r;
      if (reqS2_r != reqS3_r) begin
         rdPtrNxt   = ptr_r;
         capPendNxt = 1'b1;
      end
      if (capPend_r) begin
         rdWordNxt = rdData;
         ackTglNxt = ~ackTgl_r;
      end
   end

   always_ff @(posedge sensorClk or negedge arst_n) begin
      if (!arst_n) begin
         reqS1_r   <= 1'b0;
         reqS2_r   <= 1'b0;
         reqS3_r   <= 1'b0;
         capPend_r <= 1'b0;
         ackTgl_r  <= 1'b0;
         rdPtr_r   <= '0;
         rdWord_r  <= '0;
      end else begin
         reqS1_r   <= rdReqTgl_r;
         reqS2_r   <= reqS1_r;
         reqS3_r   <= reqS2_r;
         capPend_r <= capPendNxt;
         ackTgl_r  <= ackTglNxt;
         rdPtr_r   <= rdPtrNxt;
         rdWord_r  <= rdWordNxt;
      end
   end

   assign rdPtr = rdPtr_r;

   cdc_fifo #(.WIDTH($bits(wr_entry_t)), .DEPTH(FIFO_WORDS)) u_wrFifo (
      .wrClk   (ref_clk),
      .rdClk   (sensorClk),
      .arst_n  (arst_n),
      .wrValid (pushValid_r),
      .wrReady (fifoWrReady),
      .wrData  (pushEntry_r),
      .rdValid (wrValid),
      .rdReady (wrReady),
      .rdData  (wrEntry)
   );

   // ==========================================================
   // Checks
   a_idle_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
      state_r == ST_IDLE |-> !sdaOe_r)
      else $error("data line driven while idle");

   a_start_enter: assert property (@(posedge ref_clk) disable iff (!arst_n)
      startDet |=> (state_r == ST_ADDR) && (bitCnt_r == 4'h0) && !sdaOe_r)
      else $error("start did not open an address phase");

   a_stop_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
      stopDet |=> (state_r == ST_IDLE) && !sdaOe_r)
      else $error("stop did not return to idle");

   a_short_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (startDet || stopDet) && msbHeld_r |=> pushValid_r && !pushEntry_r.lowValid
         && (pushEntry_r.data[15:8] == $past(msb_r)))
      else $error("single-byte write not pushed as high byte only");

   a_ack_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (state_r == ST_ACK) && sclF |-> sdaOe_r)
      else $error("acknowledge released during clock high");

   a_nack_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (state_r == ST_MACK) && nack_r && sclFall && !startDet && !stopDet && !timeout
         |=> (state_r == ST_IGNORE) && !sdaOe_r [*2])
      else $error("slave kept sending after not-acknowledge");

   a_ptr_store: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (state_r == ST_PTR) && sclFall && (bitCnt_r == BITS_PER_BYTE) && !timeout
         |=> (ptr_r == $past(shift_r)) && (retState_r == ST_WDATA))
      else $error("pointer byte not stored");

   a_msb_first: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (state_r == ST_ACK) && (retState_r == ST_TX) && sclFall && wordOk && !timeout
         |=> (sdaOe_r == !$past(rdWord_r[15])) && lowNext_r)
      else $error("read did not start with the high byte");

   a_timeout_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
      timeout && !startDet && !stopDet |=> (state_r == ST_IDLE) && !sdaOe_r)
      else $error("stuck bus did not reset the interface");

   a_addr_miss: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (state_r == ST_ADDR) && sclFall && (bitCnt_r == BITS_PER_BYTE) && (shift_r[7:1] != ownAddr)
         && !timeout |=> (state_r == ST_IGNORE) && !sdaOe_r)
      else $error("answered a foreign address");

endmodule

// ==== bus_master_model.sv ====
// ====================================================
// Two-wire bus master with open-drain data output
module bus_master_model #(
   parameter int HALF = 2000
) (
   output logic      scl,
   output logic      sdaDrv,
   input  wire logic sdaLine
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      scl    = 1'b1;
      sdaDrv = 1'b1;
   end

   // Also serves as repeated start: data is released before the clock rises
   task automatic startCond();
      sdaDrv = 1'b1;
      #(HALF / 2) scl = 1'b1;
      #HALF sdaDrv = 1'b0;
      #HALF scl = 1'b0;
   endtask

   task automatic stopCond();
      #(HALF / 2) sdaDrv = 1'b0;
      #(HALF / 2) scl = 1'b1;
      #HALF sdaDrv = 1'b1;
      #HALF;
   endtask

   // Data only moves while the clock is low
   task automatic bitOut(input logic b);
      #(HALF / 2) sdaDrv = b;
      #(HALF / 2) scl = 1'b1;
      #HALF scl = 1'b0;
   endtask

   task automatic bitIn(output logic b);
      #(HALF / 2) sdaDrv = 1'b1;
      #(HALF / 2) scl = 1'b1;
      #(HALF / 2) b = sdaLine;
      #(HALF / 2) scl = 1'b0;
   endtask

   task automatic sendByte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) bitOut(d[i]);
      bitIn(ack);
   endtask

   task automatic recvByte(input logic nack, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) bitIn(d[i]);
      bitOut(nack);
   endtask
endmodule

// ==== tb_two_wire_sensor_slave_framing.sv ====
module tb_two_wire_sensor_slave_framing
   import two_wire_slave_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ====================================================
   // Clocks, bus wiring, design and master
   logic ref_clk = 1'b0, sensorClk = 1'b0, arst_n = 1'b0, wrReady = 1'b0;
   logic sdaOe, sdaOut, wrValid;
   logic [7:0] rdPtr;
   logic [15:0] rdData;
   wr_entry_t wrEntry;
   wire logic sclLine, sdaDrv;
   int pinMode = 0, errors = 0, cmp_count = 0, cycles = 0;
   // Pull-up: the line is low only while someone pulls it
   wire logic sdaLine = sdaDrv & (~sdaOe | sdaOut);
   wire logic pinLevel = (pinMode == 0) ? 1'b0 : (pinMode == 1) ? 1'b1 : (pinMode == 2) ? sdaLine : sclLine;
   assign rdData = {rdPtr, ~rdPtr};

   initial forever #20 ref_clk = ~ref_clk;
   initial begin
      #3;
      forever #7.5 sensorClk = ~sensorClk;
   end

   two_wire_slave #(.TIMEOUT_CYCLES(200)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .sensorClk(sensorClk),
      .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .addressSelectPin(pinLevel),
      .wrValid(wrValid), .wrReady(wrReady), .wrEntry(wrEntry), .rdPtr(rdPtr), .rdData(rdData));
   bus_master_model u_master (.scl(sclLine), .sdaDrv(sdaDrv), .sdaLine(sdaLine));

   // ====================================================
   // Shared tasks
   task automatic results();
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string name, input logic [24:0] exp, input logic [24:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Bounded wait for an entry, compare, then pop it with one ready cycle
   task automatic pop(input wr_entry_t exp);
      int n;
      n = 0;
      @(negedge sensorClk);
      while (wrValid !== 1'b1 && n < 300) begin
         @(negedge sensorClk);
         n++;
      end
      chk("wrEntry", exp, wrEntry);
      wrReady = 1'b1;
      @(negedge sensorClk);
      wrReady = 1'b0;
   endtask

   task automatic addr(input logic [1:0] sel, input logic rd, output logic ack);
      u_master.startCond();
      u_master.sendByte({ADDR_BASE, sel, rd}, ack);
   endtask

   // ====================================================
   // Scenarios
   task automatic testAddresses();
      logic a;
      for (int m = 0; m < 4; m++) begin
         pinMode = m;
         addr(2'(m) ^ 2'h1, 1'b0, a);
         chk("wrongAck", 1'b1, a);
         addr(2'(m), 1'b0, a);
         chk("addrAck", 1'b0, a);
         u_master.stopCond();
      end
      pinMode = 0;
   endtask

   task automatic testWrite();
      logic       a, any;
      logic [7:0] wBytes [4];
      any = 1'b0;
      wBytes = '{8'h03, 8'h11, 8'h22, 8'h33};
      addr(SEL_GND, 1'b0, a);
      any |= a;
      foreach (wBytes[i]) begin
         u_master.sendByte(wBytes[i], a);
         any |= a;
      end
      addr(SEL_GND, 1'b0, a);
      any |= a;
      u_master.sendByte(8'h05, a);
      any |= a;
      u_master.sendByte(8'hAB, a);
      any |= a;
      u_master.sendByte(8'hCD, a);
      any |= a;
      u_master.stopCond();
      chk("writeAcks", 1'b0, any);
      pop('{8'h03, 16'h1122, 1'b1});
      pop('{8'h03, 16'h3300, 1'b0});
      pop('{8'h05, 16'hABCD, 1'b1});
   endtask

   task automatic testRead();
      logic a;
      logic [7:0] d;
      addr(SEL_GND, 1'b0, a);
      u_master.sendByte(8'h07, a);
      addr(SEL_GND, 1'b1, a);
      chk("readAck", 1'b0, a);
      u_master.recvByte(1'b0, d);
      chk("readHigh", 8'h07, d);
      chk("rdPtr", 8'h07, rdPtr);
      u_master.recvByte(1'b1, d);
      chk("readLow", 8'hF8, d);
      #3000;
      chk("releasedAfterNack", 1'b0, sdaOe);
      u_master.stopCond();
   endtask

   task automatic testFull();
      logic a;
      addr(SEL_GND, 1'b0, a);
      u_master.sendByte(8'h09, a);
      for (int k = 0; k < 10; k++) u_master.sendByte(8'(k), a);
      u_master.stopCond();
      chk("fullNack", 1'b1, a);
      for (int k = 0; k < 4; k++) pop('{8'h09, {8'(2 * k), 8'(2 * k + 1)}, 1'b1});
      repeat (20) @(negedge sensorClk);
      chk("drained", 1'b0, wrValid);
   endtask

   task automatic testTimeout();
      logic a;
      addr(SEL_GND, 1'b0, a);
      #(300 * 40);
      u_master.sendByte(8'h0A, a);
      chk("ackAfterTimeout", 1'b1, a);
      u_master.stopCond();
   endtask

   // ====================================================
   // Main sequence and hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         results();
      end
   end

   initial begin
      repeat (10) @(negedge ref_clk);
      arst_n = 1'b1;
      repeat (10) @(negedge ref_clk);
      testAddresses();
      testWrite();
      testRead();
      testFull();
      testTimeout();
      results();
   end
endmodule
